/* File: hw/iemb_regs.svh */
`ifndef IEMB_REGS_SVH
`define IEMB_REGS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define IEMB_IDX_W1 8'h9a
`define IEMB_IDX_W2 8'h9c
`define IEMB_IDX_W3 8'h9e
`define IEMB_IDX_W4 8'ha0
`define IEMB_IDX_W5 8'ha2

// ****************************************
// Implemented bits and reset value
// ****************************************
`define IEMB_MASK_W1 16'h0001
`define IEMB_MASK_W2 16'h9803
`define IEMB_MASK_W3 16'hcc66
`define IEMB_MASK_W4 16'h010f
`define IEMB_MASK_W5 16'hc070
`define IEMB_RST_EN 16'h0000

// ****************************************
// Field positions
// ****************************************
`define IEMB_W1_TWI1_CLIENT 0
`define IEMB_W2_CCT5 15
`define IEMB_W2_CCT4 12
`define IEMB_W2_CCT3 11
`define IEMB_W2_SPIB_XFER 1
`define IEMB_W2_SPIB_GEN 0
`define IEMB_W3_CAPCMP1 15
`define IEMB_W3_CALENDAR 14
`define IEMB_W3_SPIB_RX 11
`define IEMB_W3_SPIA_RX 10
`define IEMB_W3_EXT4 6
`define IEMB_W3_EXT3 5
`define IEMB_W3_TWI2_HOST 2
`define IEMB_W3_TWI2_CLIENT 1
`define IEMB_W4_VDET 8
`define IEMB_W4_CHECKSUM 3
`define IEMB_W4_UARTB_ERR 2
`define IEMB_W4_UARTA_ERR 1
`define IEMB_W4_CAPCMP2 0
`define IEMB_W5_CAPCMP4 15
`define IEMB_W5_CAPCMP3 14
`define IEMB_W5_OTG 6
`define IEMB_W5_TWI2_COLL 5
`define IEMB_W5_TWI1_COLL 4

`endif

/* File: hw/iemb_pkg.sv */
package iemb_pkg;

   typedef logic [15:0] iemb_word_t;

   // One word per enable register, same bit layout as the registers
   typedef struct packed {
      iemb_word_t w5;
      iemb_word_t w4;
      iemb_word_t w3;
      iemb_word_t w2;
      iemb_word_t w1;
   } iemb_words_s;

   typedef enum {
      IEMB_IDLE,
      IEMB_ACCESS
   } iemb_phase_e;

   function automatic logic iemb_hit(logic [31:0] addr, logic [7:0] idx);
      return addr == {22'h000000, idx, 2'b00};
   endfunction

   function automatic iemb_word_t iemb_merge(iemb_word_t old, iemb_word_t wd,
                                             logic [1:0] strb, iemb_word_t mask);
      iemb_word_t lanes;
      lanes = {{8{strb[1]}}, {8{strb[0]}}};
      return ((old & ~lanes) | (wd & lanes)) & mask;
   endfunction

endpackage

/* File: hw/iemb_apb_slave.sv */
`timescale 1ns/1ps
`include "iemb_regs.svh"

module iemb_apb_slave #(
   parameter int ADDR_W = 12
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire iemb_pkg::iemb_words_s rd_words,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output logic [4:0] wr_sel,
   output iemb_pkg::iemb_word_t wr_data,
   output logic [1:0] wr_strb
);

   iemb_pkg::iemb_phase_e phase;
   logic [4:0] hit;
   logic [4:0] latched_sel;
   logic [31:0] addr32;
   iemb_pkg::iemb_word_t rd_mux;

   assign addr32 = 32'(paddr);

   always_comb
   begin
      hit[0] = iemb_pkg::iemb_hit(addr32, `IEMB_IDX_W1);
      hit[1] = iemb_pkg::iemb_hit(addr32, `IEMB_IDX_W2);
      hit[2] = iemb_pkg::iemb_hit(addr32, `IEMB_IDX_W3);
      hit[3] = iemb_pkg::iemb_hit(addr32, `IEMB_IDX_W4);
      hit[4] = iemb_pkg::iemb_hit(addr32, `IEMB_IDX_W5);
      rd_mux = ({16{hit[0]}} & rd_words.w1) | ({16{hit[1]}} & rd_words.w2)
             | ({16{hit[2]}} & rd_words.w3) | ({16{hit[3]}} & rd_words.w4)
             | ({16{hit[4]}} & rd_words.w5);
   end

   // ****************************************
   // Protocol: answer in the first access cycle
   // ****************************************
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         phase <= iemb_pkg::IEMB_IDLE;
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         latched_sel <= 5'h00;
      end
      else
      begin
         case (phase)
            iemb_pkg::IEMB_IDLE:
            begin
               pready <= 1'b0;
               pslverr <= 1'b0;
               if (psel && !penable)
               begin
                  phase <= iemb_pkg::IEMB_ACCESS;
                  pready <= 1'b1;
                  // Unmapped or misaligned address answers with an error
                  pslverr <= (hit == 5'h00);
                  prdata <= pwrite ? 32'h00000000 : {16'h0000, rd_mux};
                  latched_sel <= hit;
               end
            end
            iemb_pkg::IEMB_ACCESS:
            begin
               phase <= iemb_pkg::IEMB_IDLE;
               pready <= 1'b0;
               pslverr <= 1'b0;
               prdata <= 32'h00000000;
               latched_sel <= 5'h00;
            end
            default:
            begin
               phase <= iemb_pkg::IEMB_IDLE;
               pready <= 1'b0;
            end
         endcase
      end
   end

   // Write takes effect at the edge that samples pready high
   assign wr_sel = (phase == iemb_pkg::IEMB_ACCESS && psel && penable && pwrite)
                   ? latched_sel : 5'h00;
   assign wr_data = pwdata[15:0];
   assign wr_strb = pstrb[1:0];

endmodule

/* File: hw/iemb_top.sv */
// Contract
// R1 - Word 1 bit 0 enables the first two-wire client-event request.
// R2 - Word 2 bits 15, 12, 11 enable capture/timer units five, four, three.
// R3 - Word 2 bit 1 enables SPI B transfer-done, bit 0 its general request.
// R4 - Word 3 bit 15 enables capture unit one, bit 14 the calendar.
// R5 - Word 3 bits 11 and 10 enable SPI B and SPI A receive-done.
// R6 - Word 3 bits 6 and 5 enable external pins four and three.
// R7 - Word 3 bit 2 enables second two-wire host, bit 1 its client events.
// R8 - Word 4 bit 8 enables voltage detect, bit 3 the checksum unit.
// R9 - Word 4 bits 2, 1 enable UART B/A errors, bit 0 capture two.
// R10 - Word 5 bits 15 and 14 enable capture units four and three.
// R11 - Word 5 bit 6 enables the USB on-the-go controller request.
// R12 - Word 5 bits 5 and 4 enable two-wire bus collision, second and first.
// R13 - Reset clears every enable bit so all sources start masked.
// R14 - Request passes only while flag and enable are both one; flag untouched.
// R15 - Unimplemented bits read zero and ignore writes.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "iemb_regs.svh"

module iemb_top #(
   parameter int ADDR_W = 12
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire iemb_pkg::iemb_words_s flags,
   output iemb_pkg::iemb_words_s en,
   output iemb_pkg::iemb_words_s req
);

   logic [4:0] wr_sel;
   iemb_pkg::iemb_word_t wr_data;
   logic [1:0] wr_strb;

   // ****************************************
   // Bus slave
   // ****************************************
   iemb_apb_slave #(
      .ADDR_W(ADDR_W)
   ) u_apb (
      .core_clk(core_clk),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .rd_words(en),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .wr_sel(wr_sel),
      .wr_data(wr_data),
      .wr_strb(wr_strb)
   );

   // ****************************************
   // Enable registers
   // ****************************************
   // Masks keep unimplemented bits at zero whatever is written
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         en.w1 <= `IEMB_RST_EN; // R13
         en.w2 <= `IEMB_RST_EN; // R13
         en.w3 <= `IEMB_RST_EN; // R13
         en.w4 <= `IEMB_RST_EN; // R13
         en.w5 <= `IEMB_RST_EN; // R13
      end
      else
      begin
         if (wr_sel[0])
         begin
            en.w1 <= iemb_pkg::iemb_merge(en.w1, wr_data, wr_strb, `IEMB_MASK_W1); // R1 R15
         end
         if (wr_sel[1])
         begin
            en.w2 <= iemb_pkg::iemb_merge(en.w2, wr_data, wr_strb, `IEMB_MASK_W2); // R2 R3 R15
         end
         if (wr_sel[2])
         begin
            en.w3 <= iemb_pkg::iemb_merge(en.w3, wr_data, wr_strb, `IEMB_MASK_W3); // R4 R5 R6 R7
         end
         if (wr_sel[3])
         begin
            en.w4 <= iemb_pkg::iemb_merge(en.w4, wr_data, wr_strb, `IEMB_MASK_W4); // R8 R9 R15
         end
         if (wr_sel[4])
         begin
            en.w5 <= iemb_pkg::iemb_merge(en.w5, wr_data, wr_strb, `IEMB_MASK_W5); // R10 R11 R12
         end
      end
   end

   // ****************************************
   // Request gating
   // ****************************************
   // Registered so the arbiter sees a glitch-free level; costs one cycle
   // of latency. Flags are only read here, never modified.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         req <= '0; // R13
      end
      else
      begin
         req <= flags & en; // R14
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Lane-wise model of a strobed write, kept apart from the bus merge
   function automatic iemb_pkg::iemb_word_t lane_expect(iemb_pkg::iemb_word_t old,
      iemb_pkg::iemb_word_t wd, logic [1:0] strb, iemb_pkg::iemb_word_t mask);
      iemb_pkg::iemb_word_t res;
      res = old & mask;
      if (strb[0])
      begin
         res[7:0] = wd[7:0] & mask[7:0];
      end
      if (strb[1])
      begin
         res[15:8] = wd[15:8] & mask[15:8];
      end
      return res;
   endfunction

   logic past_ok;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         past_ok <= 1'b0;
      end
      else
      begin
         past_ok <= 1'b1;
      end
   end

   a_twi1_client_gate: assert property ( // R1
      past_ok |-> req.w1[`IEMB_W1_TWI1_CLIENT] ==
         ($past(flags.w1[`IEMB_W1_TWI1_CLIENT]) && $past(en.w1[`IEMB_W1_TWI1_CLIENT])))
      else $error("first two-wire client request not gated by its enable");

   a_cct_gate: assert property ( // R2
      past_ok |-> {req.w2[`IEMB_W2_CCT5], req.w2[`IEMB_W2_CCT4], req.w2[`IEMB_W2_CCT3]} ==
         ($past({flags.w2[`IEMB_W2_CCT5], flags.w2[`IEMB_W2_CCT4], flags.w2[`IEMB_W2_CCT3]})
        & $past({en.w2[`IEMB_W2_CCT5], en.w2[`IEMB_W2_CCT4], en.w2[`IEMB_W2_CCT3]})))
      else $error("capture timer request gating wrong");

   a_spib_xfer_gate: assert property ( // R3
      (flags.w2[`IEMB_W2_SPIB_XFER] && !en.w2[`IEMB_W2_SPIB_XFER]
       && !wr_sel[1]) [*2] |-> !req.w2[`IEMB_W2_SPIB_XFER])
      else $error("masked SPI B transfer-done request leaked");

   a_spib_gen_gate: assert property ( // R3
      flags.w2[`IEMB_W2_SPIB_GEN] && en.w2[`IEMB_W2_SPIB_GEN]
      |=> req.w2[`IEMB_W2_SPIB_GEN])
      else $error("enabled SPI B general request not passed");

   a_word3_hi_gate: assert property ( // R4
      past_ok |-> req.w3[15:14] == ($past(flags.w3[15:14]) & $past(en.w3[15:14])))
      else $error("capture one or calendar request gating wrong");

   a_spi_rx_gate: assert property ( // R5
      past_ok |-> req.w3[`IEMB_W3_SPIB_RX:`IEMB_W3_SPIA_RX] ==
         ($past(flags.w3[`IEMB_W3_SPIB_RX:`IEMB_W3_SPIA_RX])
        & $past(en.w3[`IEMB_W3_SPIB_RX:`IEMB_W3_SPIA_RX])))
      else $error("SPI receive-done request gating wrong");

   a_ext_pin_gate: assert property ( // R6
      past_ok |-> req.w3[`IEMB_W3_EXT4:`IEMB_W3_EXT3] ==
         ($past(flags.w3[`IEMB_W3_EXT4:`IEMB_W3_EXT3])
        & $past(en.w3[`IEMB_W3_EXT4:`IEMB_W3_EXT3])))
      else $error("external pin request gating wrong");

   a_twi2_gate: assert property ( // R7
      past_ok |-> req.w3[`IEMB_W3_TWI2_HOST:`IEMB_W3_TWI2_CLIENT] ==
         ($past(flags.w3[`IEMB_W3_TWI2_HOST:`IEMB_W3_TWI2_CLIENT])
        & $past(en.w3[`IEMB_W3_TWI2_HOST:`IEMB_W3_TWI2_CLIENT])))
      else $error("second two-wire request gating wrong");

   a_word4_gate: assert property ( // R8
      past_ok |-> {req.w4[`IEMB_W4_VDET], req.w4[`IEMB_W4_CHECKSUM]} ==
         ($past({flags.w4[`IEMB_W4_VDET], flags.w4[`IEMB_W4_CHECKSUM]})
        & $past({en.w4[`IEMB_W4_VDET], en.w4[`IEMB_W4_CHECKSUM]})))
      else $error("voltage detect or checksum gating wrong");

   a_word4_lo_gate: assert property ( // R9
      past_ok |-> req.w4[2:0] == ($past(flags.w4[2:0]) & $past(en.w4[2:0])))
      else $error("UART error or capture two gating wrong");

   a_capcmp_gate: assert property ( // R10
      past_ok |-> req.w5[15:14] == ($past(flags.w5[15:14]) & $past(en.w5[15:14])))
      else $error("capture four or three gating wrong");

   a_otg_gate: assert property ( // R11
      past_ok |-> req.w5[`IEMB_W5_OTG] ==
         ($past(flags.w5[`IEMB_W5_OTG]) && $past(en.w5[`IEMB_W5_OTG])))
      else $error("on-the-go request gating wrong");

   a_collision_gate: assert property ( // R12
      past_ok |-> req.w5[`IEMB_W5_TWI2_COLL:`IEMB_W5_TWI1_COLL] ==
         ($past(flags.w5[`IEMB_W5_TWI2_COLL:`IEMB_W5_TWI1_COLL])
        & $past(en.w5[`IEMB_W5_TWI2_COLL:`IEMB_W5_TWI1_COLL])))
      else $error("bus collision request gating wrong");

   a_reset_clears: assert property (@(posedge core_clk) disable iff (1'b0) // R13
      rst |=> (en == '0) && (req == '0))
      else $error("reset did not clear enables and requests");

   a_req_needs_en: assert property ( // R14
      past_ok |-> (req & ~$past(en)) == '0)
      else $error("request passed without its enable");

   a_unimpl_zero: assert property ( // R15
      ((en.w1 & ~`IEMB_MASK_W1) == 16'h0000) && ((en.w2 & ~`IEMB_MASK_W2) == 16'h0000)
      && ((en.w3 & ~`IEMB_MASK_W3) == 16'h0000) && ((en.w4 & ~`IEMB_MASK_W4) == 16'h0000)
      && ((en.w5 & ~`IEMB_MASK_W5) == 16'h0000))
      else $error("unimplemented enable bit became set");

   a_write_lands: assert property ( // R15
      wr_sel[2] |=> en.w3 == ($past(wr_data) & `IEMB_MASK_W3 & {{8{$past(wr_strb[1])}},
         {8{$past(wr_strb[0])}}} | $past(en.w3) & ~{{8{$past(wr_strb[1])}},
         {8{$past(wr_strb[0])}}}))
      else $error("word 3 write did not land as masked");

   a_ready_once: assert property (
      psel && !penable && !pready |=> pready ##1 !pready)
      else $error("slave answer not one cycle after setup");

   a_ready_single: assert property (
      pready |=> !pready)
      else $error("answer stood longer than one cycle");

   a_write_word1: assert property ( // R1 R15
      wr_sel[0] |=> en.w1 == lane_expect($past(en.w1), $past(wr_data), $past(wr_strb),
         `IEMB_MASK_W1))
      else $error("word 1 write did not land as masked");

   a_write_word2: assert property ( // R2 R3 R15
      wr_sel[1] |=> en.w2 == lane_expect($past(en.w2), $past(wr_data), $past(wr_strb),
         `IEMB_MASK_W2))
      else $error("word 2 write did not land as masked");

   a_write_word4: assert property ( // R8 R9 R15
      wr_sel[3] |=> en.w4 == lane_expect($past(en.w4), $past(wr_data), $past(wr_strb),
         `IEMB_MASK_W4))
      else $error("word 4 write did not land as masked");

   a_write_word5: assert property ( // R10 R11 R12 R15
      wr_sel[4] |=> en.w5 == lane_expect($past(en.w5), $past(wr_data), $past(wr_strb),
         `IEMB_MASK_W5))
      else $error("word 5 write did not land as masked");

   a_en_holds: assert property (
      wr_sel == 5'h00 |=> en == $past(en))
      else $error("enable word changed without a write");

   a_no_lane_write: assert property (
      wr_sel != 5'h00 && wr_strb == 2'b00 |=> en == $past(en))
      else $error("write with no byte lanes changed an enable word");

   a_rdata_idle: assert property (
      !pready |-> prdata == 32'h00000000)
      else $error("read data shown outside the answer cycle");

   a_rdata_upper: assert property ( // R15
      prdata[31:16] == 16'h0000)
      else $error("upper read data lanes not zero");

   a_err_with_ready: assert property (
      pslverr |-> pready)
      else $error("error response outside the answer cycle");

   a_err_no_write: assert property (
      pready && pslverr |-> wr_sel == 5'h00)
      else $error("refused transfer reached an enable word");

   c_write_read: cover property (
      wr_sel[1] ##[1:10] (pready && !pwrite && prdata[15:0] != 16'h0000));

   c_error_resp: cover property (pready && pslverr);

   c_req_rise: cover property ($rose(req.w5[`IEMB_W5_OTG]));

   c_mask_drop: cover property (
      req.w3[`IEMB_W3_EXT4] ##1 (flags.w3[`IEMB_W3_EXT4] && !req.w3[`IEMB_W3_EXT4]));

   c_back_to_back: cover property (pready ##1 (psel && !penable) ##1 pready);

endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
   logic core_clk;
   logic rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   iemb_pkg::iemb_words_s flags;
   iemb_pkg::iemb_words_s en;
   iemb_pkg::iemb_words_s req;
   int failures;
   int checked;
   logic [31:0] rd;
   logic er;
   logic [79:0] ev;
   logic [79:0] fv;
   // Byte addresses and implemented bits, word 1 first
   localparam logic [11:0] ADR [5] = '{12'h268, 12'h270, 12'h278, 12'h280, 12'h288};
   localparam logic [15:0] MSK [5] = '{16'h0001, 16'h9803, 16'hcc66, 16'h010f, 16'hc070};
   // Unmapped, misaligned and out-of-range addresses
   localparam logic [11:0] BAD [4] = '{12'h26c, 12'h271, 12'h290, 12'ha70};

   iemb_top #(.ADDR_W(12)) DUT (
      .core_clk(core_clk),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .flags(flags),
      .en(en),
      .req(req)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ****************************************
   // Reporting
   // ****************************************
   task print_verdict;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task chk_bus(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: bus got %h expected %h", $time, got, exp);
      end
   endtask

   task chk_vec(input logic [79:0] got, input logic [79:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: word set got %h expected %h", $time, got, exp);
      end
   endtask

   // ****************************************
   // Bus access
   // ****************************************
   // Leaves the bus requested so that a next setup may follow at once
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         failures++;
         $display("mismatch at %0t: no ready", $time);
         print_verdict();
      end
      else
      begin
         rd = prdata;
         er = pslverr;
      end
   endtask

   task idle;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      xfer(1'b1, a, d, s);
      idle();
   endtask

   task rdr(input logic [11:0] a);
      xfer(1'b0, a, 32'h0, 4'h0);
      idle();
   endtask

   // Enables land one edge late and requests one edge after that
   task settle;
      repeat (3) @(posedge core_clk);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      flags = '1;
      failures = 0;
      checked = 0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 5; i++)
      begin
         rdr(ADR[i]);
         chk_bus(rd, 32'h0);
      end
      chk_vec(en, 80'h0);
      chk_vec(req, 80'h0);
      // Walking one per word; upper data lanes are driven high to show they are dropped
      for (int i = 0; i < 5; i++)
      begin
         for (int b = 0; b < 16; b++)
         begin
            ev = '0;
            ev[16*i +: 16] = MSK[i] & (16'h0001 << b);
            wr(ADR[i], {16'hffff, 16'h0001 << b}, 4'hf);
            rdr(ADR[i]);
            chk_bus(rd, {16'h0000, ev[16*i +: 16]});
            settle();
            chk_vec(en, ev);
            chk_vec(req, ev);
         end
         wr(ADR[i], 32'h0, 4'h3);
      end
      for (int i = 0; i < 5; i++)
         xfer(1'b1, ADR[i], 32'hffffffff, 4'hf);
      for (int i = 0; i < 5; i++)
      begin
         xfer(1'b0, ADR[i], 32'h0, 4'h0);
         chk_bus(rd, {16'h0000, MSK[i]});
         chk_bus({31'h0, er}, 32'h0);
      end
      idle();
      ev = {MSK[4], MSK[3], MSK[2], MSK[1], MSK[0]};
      settle();
      chk_vec(en, ev);
      wr(ADR[2], 32'h0, 4'h1);
      rdr(ADR[2]);
      chk_bus(rd, 32'h0000cc00);
      wr(ADR[1], 32'h0, 4'h0);
      rdr(ADR[1]);
      chk_bus(rd, 32'h00009803);
      // High lane alone: only bit 8 of word 4 lies there
      wr(ADR[3], 32'h0, 4'h2);
      rdr(ADR[3]);
      chk_bus(rd, 32'h0000000f);
      ev[47:32] = 16'hcc00;
      ev[63:48] = 16'h000f;
      fv = 80'h5555_aaaa_0f0f_f0f0_ffff;
      // The edge that launches the new flags still gates the old ones
      flags <= fv;
      @(posedge core_clk);
      chk_vec(req, ev);
      @(posedge core_clk);
      chk_vec(req, fv & ev);
      wr(ADR[4], 32'h0, 4'h3);
      ev[79:64] = 16'h0000;
      settle();
      chk_vec(en, ev);
      chk_vec(req, fv & ev);
      for (int i = 0; i < 4; i++)
      begin
         xfer(1'b1, BAD[i], 32'hffffffff, 4'hf);
         chk_bus({31'h0, er}, 32'h1);
         xfer(1'b0, BAD[i], 32'h0, 4'h0);
         chk_bus(rd, 32'h0);
         chk_bus({31'h0, er}, 32'h1);
         idle();
      end
      settle();
      chk_vec(en, ev);
      // A second reset in mid-run must drop every enable again
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chk_vec(en, 80'h0);
      chk_vec(req, 80'h0);
      rdr(ADR[2]);
      chk_bus(rd, 32'h0);
      print_verdict();
   end
endmodule
